/* File: hw/eau_top.sv */
// Effective address unit: forms operand addresses, write-back values and
// extended immediates, registered one cycle after the decoder presents them.
// Assumes the pipeline gives pc, mode, size and register values in one cycle.
//
// Overview of operation
// - Register direct passes register n, no address.
// - Post-increment: address register n, then add 1/2/4.
// - Pre-decrement: subtract 1/2/4, write back, use it.
// - Zero-extend 4-bit displacement, scale, add register n.
// - Index mode adds register n and register zero.
// - Zero-extend 8-bit displacement, scale, add base register.
// - Indexed base adds base register and register zero.
// - PC data: zero-extend 8-bit, scale 2/4, add PC.
// - Longword PC data masks low two PC bits.
// - 8-bit branch: sign-extend, double, add PC.
// - 12-bit branch: sign-extend, double, add PC.
// - Register PC-relative adds PC and register n.
// - Logical immediates are zero-extended to 32 bits.
// - Move/add/compare immediates are sign-extended.
// - Trap immediate zero-extended, times four.
`timescale 1ns/1ns
`default_nettype none
module eau_top (
	input  wire logic               sys_clk_in,
	input  wire logic               rst_n_in,
	input  wire logic               valid_in,
	input  wire eau_pkg::eau_mode_e mode_in,
	input  wire eau_pkg::eau_size_e size_in,
	input  wire logic [3:0]         reg_sel_in,
	input  wire logic [31:0]        general_register_n_in,
	input  wire logic [31:0]        general_register_zero_in,
	input  wire logic [31:0]        global_base_register_in,
	input  wire logic [31:0]        pc_in,
	input  wire logic [11:0]        field_in,
	output logic                    valid_out,
	output logic                    addr_valid_out,
	output logic [31:0]             addr_out,
	output logic                    operand_valid_out,
	output logic [31:0]             operand_out,
	output logic                    wb_en_out,
	output logic [3:0]              wb_sel_out,
	output logic [31:0]             wb_data_out
);
	import eau_pkg::*;

	// ==========================================================
	// Scaling of unsigned displacements
	wire logic [31:0] step;
	wire logic [31:0] scaled;
	wire logic [7:0]  disp_field = (mode_in == EAU_REG_DISP4) ?
		{4'h0, field_in[3:0]} : field_in[7:0];

	eau_scale u_scale (
		.size_in    (size_in),
		.field_in   (disp_field),
		.step_out   (step),
		.scaled_out (scaled)
	);

	// ==========================================================
	// Address candidates; all share the values sampled in one cycle
	wire logic        is_long   = (size_in == EAU_SIZE_LONG);
	wire logic [31:0] pc_base   = is_long ? (pc_in & EAU_PC_LONG_MASK) : pc_in;
	// PC data has no byte form; word scaling applies unless longword
	wire logic [31:0] pc_scaled = {22'h000000, field_in[7:0], 2'h0} >> (is_long ? 0 : 1);
	wire logic [31:0] br8_off   = {{23{field_in[7]}}, field_in[7:0], 1'h0};
	wire logic [31:0] br12_off  = {{19{field_in[11]}}, field_in[11:0], 1'h0};
	wire logic [31:0] dec_value = general_register_n_in - step;
	wire logic [31:0] inc_value = general_register_n_in + step;
	wire logic [31:0] imm_zero  = {24'h000000, field_in[7:0]};
	wire logic [31:0] imm_sign  = {{24{field_in[7]}}, field_in[7:0]};
	wire logic [31:0] imm_trap  = {22'h000000, field_in[7:0], 2'h0};

	logic [31:0] next_addr;
	logic [31:0] next_operand;
	logic        next_addr_valid;
	logic        next_wb_en;
	logic [31:0] next_wb_data;

	always_comb begin
		next_addr       = EAU_RESET_VALUE;
		next_operand    = EAU_RESET_VALUE;
		next_addr_valid = 1'b0;
		next_wb_en      = 1'b0;
		next_wb_data    = EAU_RESET_VALUE;
		unique case (mode_in)
			EAU_REG_DIRECT: begin
				next_operand = general_register_n_in;
			end
			EAU_REG_IND: begin
				next_addr       = general_register_n_in;
				next_addr_valid = 1'b1;
			end
			EAU_POST_INC: begin
				next_addr       = general_register_n_in;
				next_addr_valid = 1'b1;
				next_wb_en      = 1'b1;
				next_wb_data    = inc_value;
			end
			EAU_PRE_DEC: begin
				next_addr       = dec_value;
				next_addr_valid = 1'b1;
				next_wb_en      = 1'b1;
				next_wb_data    = dec_value;
			end
			EAU_REG_DISP4: begin
				next_addr       = general_register_n_in + scaled;
				next_addr_valid = 1'b1;
			end
			EAU_INDEX_R0: begin
				next_addr       = general_register_n_in + general_register_zero_in;
				next_addr_valid = 1'b1;
			end
			EAU_GBR_DISP8: begin
				next_addr       = global_base_register_in + scaled;
				next_addr_valid = 1'b1;
			end
			EAU_GBR_INDEX: begin
				next_addr       = global_base_register_in + general_register_zero_in;
				next_addr_valid = 1'b1;
			end
			EAU_PC_DISP8: begin
				next_addr       = pc_base + pc_scaled;
				next_addr_valid = 1'b1;
			end
			EAU_PC_BRANCH8: begin
				next_addr       = pc_in + br8_off;
				next_addr_valid = 1'b1;
			end
			EAU_PC_BRANCH12: begin
				next_addr       = pc_in + br12_off;
				next_addr_valid = 1'b1;
			end
			EAU_PC_REG: begin
				next_addr       = pc_in + general_register_n_in;
				next_addr_valid = 1'b1;
			end
			EAU_IMM_ZERO: begin
				next_operand = imm_zero;
			end
			EAU_IMM_SIGN: begin
				next_operand = imm_sign;
			end
			EAU_IMM_TRAP: begin
				next_operand = imm_trap;
			end
			EAU_IDLE: begin
				next_operand = EAU_RESET_VALUE;
			end
		endcase
	end

	wire logic next_operand_valid = (mode_in == EAU_REG_DIRECT) ||
		(mode_in == EAU_IMM_ZERO) || (mode_in == EAU_IMM_SIGN) ||
		(mode_in == EAU_IMM_TRAP);

	// ==========================================================
	// Output registers; only the valid and enable flags are qualified by valid_in, data and wb_sel_out are not
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			valid_out         <= 1'b0;
			addr_valid_out    <= 1'b0;
			addr_out          <= EAU_RESET_VALUE;
			operand_valid_out <= 1'b0;
			operand_out       <= EAU_RESET_VALUE;
			wb_en_out         <= 1'b0;
			wb_sel_out        <= EAU_REG_RESET;
			wb_data_out       <= EAU_RESET_VALUE;
		end else begin
			valid_out         <= valid_in;
			addr_valid_out    <= valid_in & next_addr_valid;
			addr_out          <= next_addr;
			operand_valid_out <= valid_in & next_operand_valid;
			operand_out       <= next_operand;
			wb_en_out         <= valid_in & next_wb_en;
			wb_sel_out        <= reg_sel_in;
			wb_data_out       <= next_wb_data;
		end
	end
endmodule
`default_nettype wire

/* File: shared/eau_pkg.sv */
// Package for the effective address unit: modes, sizes, field widths, constants.
// Assumes a 32-bit datapath and fixed 16-bit instructions decoded upstream.
package eau_pkg;
	// ==========================================================
	// Operand modes
	typedef enum logic [3:0] {
		EAU_REG_DIRECT  = 4'h0,
		EAU_REG_IND     = 4'h1,
		EAU_POST_INC    = 4'h2,
		EAU_PRE_DEC     = 4'h3,
		EAU_REG_DISP4   = 4'h4,
		EAU_INDEX_R0    = 4'h5,
		EAU_GBR_DISP8   = 4'h6,
		EAU_GBR_INDEX   = 4'h7,
		EAU_PC_DISP8    = 4'h8,
		EAU_PC_BRANCH8  = 4'h9,
		EAU_PC_BRANCH12 = 4'hA,
		EAU_PC_REG      = 4'hB,
		EAU_IMM_ZERO    = 4'hC,
		EAU_IMM_SIGN    = 4'hD,
		EAU_IMM_TRAP    = 4'hE,
		EAU_IDLE        = 4'hF
	} eau_mode_e;

	// ==========================================================
	// Operand sizes
	typedef enum logic [1:0] {
		EAU_SIZE_BYTE = 2'h0,
		EAU_SIZE_WORD = 2'h1,
		EAU_SIZE_LONG = 2'h2
	} eau_size_e;

	localparam int EAU_DATA_W   = 32;
	localparam int EAU_DISP12_W = 12;
	localparam logic [31:0] EAU_PC_LONG_MASK = 32'hFFFFFFFC;
	localparam logic [31:0] EAU_RESET_VALUE  = 32'h00000000;
	localparam logic [3:0]  EAU_REG_RESET    = 4'h0;
endpackage

/* File: hw/eau_scale.sv */
// Scaler: turns operand size into step 1/2/4 and scales a zero-extended field.
// Assumes size codes from eau_pkg; purely combinational, no state.
`timescale 1ns/1ns
`default_nettype none
module eau_scale (
	input  wire eau_pkg::eau_size_e size_in,
	input  wire logic [7:0]         field_in,
	output logic [31:0]             step_out,
	output logic [31:0]             scaled_out
);
	import eau_pkg::*;

	// Illegal size code scales by one, like a byte
	wire logic [1:0] shift = (size_in == EAU_SIZE_LONG) ? 2'h2 :
		(size_in == EAU_SIZE_WORD) ? 2'h1 : 2'h0;

	assign step_out   = 32'h00000001 << shift;
	assign scaled_out = {24'h000000, field_in} << shift;
endmodule
`default_nettype wire

/* File: verification/eau_mem_model.sv */
// Memory-stage model: takes each address and applies each write-back.
// Assumes eau_top outputs stand for one cycle only.
`timescale 1ns/1ns
`default_nettype none
module eau_mem_model (
	input  wire logic        sys_clk_in,
	input  wire logic        addr_valid_in,
	input  wire logic [31:0] addr_in,
	input  wire logic        wb_en_in,
	input  wire logic [31:0] wb_data_in,
	output logic      [31:0] last_addr_out,
	output logic      [31:0] reg_n_out
);
	// Sampled in their one valid cycle, so a late read would miss them
	always_ff @(posedge sys_clk_in) begin
		if (addr_valid_in) last_addr_out <= addr_in;
		if (wb_en_in) reg_n_out <= wb_data_in;
	end
endmodule
`default_nettype wire

/* File: verification/eau_checker.sv */
// Checker: address and operand relations of eau_top, one cycle after a take.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module eau_checker
	import eau_pkg::*;
(
	input wire logic sys_clk_in, rst_n_in, valid_in, addr_valid_out, operand_valid_out, wb_en_out,
	input wire eau_mode_e mode_in,
	input wire eau_size_e size_in,
	input wire logic [11:0] field_in,
	input wire logic [31:0] general_register_n_in, general_register_zero_in,
	input wire logic [31:0] global_base_register_in, pc_in, addr_out, operand_out, wb_data_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	// ==========================================================
	// Requests
	sequence s_take(logic [3:0] m);
		valid_in && mode_in == m;
	endsequence
	chk_reg_direct: assert property (s_take(4'h0) |=> operand_valid_out && !addr_valid_out
		&& operand_out == $past(general_register_n_in)) else $error("reg direct wrong");
	chk_post_inc_step: assert property (s_take(4'h2) ##0 size_in == EAU_SIZE_LONG |=> wb_en_out
		&& addr_out + 32'h4 == wb_data_out && addr_out == $past(general_register_n_in))
		else $error("post inc wrong");
	chk_pre_dec_word: assert property (s_take(4'h3) ##0 size_in == EAU_SIZE_WORD |=> wb_en_out
		&& addr_out == wb_data_out && addr_out == $past(general_register_n_in) - 32'h2)
		else $error("pre dec wrong");
	chk_index_sum: assert property (s_take(4'h5) |=> addr_out ==
		$past(general_register_n_in) + $past(general_register_zero_in)) else $error("index wrong");
	chk_gbr_index: assert property (s_take(4'h7) |=> addr_out ==
		$past(global_base_register_in) + $past(general_register_zero_in)) else $error("gbr wrong");
	chk_pc_long_mask: assert property (s_take(4'h8) ##0 size_in == EAU_SIZE_LONG |=> addr_out ==
		($past(pc_in) & 32'hFFFFFFFC) + ({$past(field_in), 2'h0} & 32'h3FC)) else $error("pc long wrong");
	chk_branch_far: assert property (s_take(4'hA) |=> addr_out ==
		$past(pc_in) + (32'($signed($past(field_in))) << 1)) else $error("branch12 wrong");
	chk_pc_reg_sum: assert property (s_take(4'hB) |=> addr_valid_out && addr_out ==
		$past(pc_in) + $past(general_register_n_in)) else $error("pc reg wrong");
	chk_trap_scale: assert property (s_take(4'hE) |=> operand_valid_out && operand_out ==
		({$past(field_in), 2'h0} & 32'h3FC)) else $error("trap wrong");
endmodule
bind eau_top eau_checker u_chk (.sys_clk_in, .rst_n_in, .valid_in, .addr_valid_out,
	.operand_valid_out, .wb_en_out, .mode_in, .size_in, .field_in, .general_register_n_in,
	.general_register_zero_in, .global_base_register_in, .pc_in, .addr_out, .operand_out,
	.wb_data_out);
`default_nettype wire

/* File: verification/effective_address_unit_tb_top.sv */
// Bench for eau_top: a table of modes back to back, then reset and idle cases.
// Assumes the one-cycle answer of eau_top; pc, base and register zero are fixed.
`timescale 1ns/1ns
`default_nettype none
module effective_address_unit_tb_top;
	import eau_pkg::*;
	typedef struct packed {logic [3:0] m; logic [1:0] s; logic [11:0] f; logic [31:0] x;} eau_row_s;
	logic        sys_clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        valid_in = 1'b0;
	eau_mode_e   mode_in = EAU_IDLE;
	eau_size_e   size_in = EAU_SIZE_BYTE;
	logic [11:0] field_in = 12'h0;
	logic        valid_out, addr_valid_out, operand_valid_out, wb_en_out;
	logic [31:0] addr_out, operand_out, wb_data_out, last_addr, reg_n;
	logic [3:0]  wb_sel;
	int          err_total = 0;
	int          compares = 0;
	eau_row_s    rows [19] = '{'{4'h0,2'h2,12'h0,32'h100}, '{4'h1,2'h2,12'h0,32'h100},
		'{4'h2,2'h2,12'h0,32'h100}, '{4'h3,2'h0,12'h0,32'hFF}, '{4'h3,2'h1,12'h0,32'hFE},
		'{4'h4,2'h1,12'h3,32'h106}, '{4'h4,2'h0,12'hF,32'h10F}, '{4'h5,2'h2,12'h0,32'h120},
		'{4'h6,2'h2,12'hFF,32'h13FC}, '{4'h7,2'h0,12'h0,32'h1020}, '{4'h8,2'h1,12'h2,32'h1006},
		'{4'h8,2'h2,12'h2,32'h1008}, '{4'h9,2'h1,12'hFF,32'h1000}, '{4'hA,2'h1,12'h800,32'h2},
		'{4'hA,2'h1,12'h7FF,32'h2000}, '{4'hB,2'h2,12'h0,32'h1102}, '{4'hC,2'h2,12'h80,32'h80},
		'{4'hD,2'h2,12'h80,32'hFFFFFF80}, '{4'hE,2'h2,12'hFF,32'h3FC}};
	eau_top u_dut (.sys_clk_in, .rst_n_in, .valid_in, .mode_in, .size_in, .reg_sel_in(4'h5),
		.general_register_n_in(32'h100), .general_register_zero_in(32'h20),
		.global_base_register_in(32'h1000), .pc_in(32'h1002), .field_in, .valid_out,
		.addr_valid_out, .addr_out, .operand_valid_out, .operand_out, .wb_en_out,
		.wb_sel_out(wb_sel), .wb_data_out);
	eau_mem_model u_mem (.sys_clk_in, .addr_valid_in(addr_valid_out), .addr_in(addr_out),
		.wb_en_in(wb_en_out), .wb_data_in(wb_data_out), .last_addr_out(last_addr), .reg_n_out(reg_n));
	always #50 sys_clk_in = ~sys_clk_in;
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ==========================================================
	// Table, one request every cycle, then reset and idle cases
	initial begin
		repeat (3) @(posedge sys_clk_in);
		#1 check(addr_out | operand_out | wb_data_out, 32'h0);
		rst_n_in <= 1'b1;
		for (int i = 0; i <= 19; i++) begin
			@(posedge sys_clk_in);
			valid_in <= i < 19;
			if (i < 19) begin
				mode_in <= eau_mode_e'(rows[i].m);
				size_in <= eau_size_e'(rows[i].s);
				field_in <= rows[i].f;
			end
			#1;
			if (i > 0) check(rows[i-1].m inside {4'h0, 4'hC, 4'hD, 4'hE} ? operand_out : addr_out, rows[i-1].x);
		end
		$display("table done");
		valid_in <= 1'b1;
		mode_in <= EAU_POST_INC;
		size_in <= EAU_SIZE_BYTE;
		@(posedge sys_clk_in);
		valid_in <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
		#1 check(reg_n, 32'h101);
		check(last_addr, 32'h100);
		valid_in <= 1'b1;
		mode_in <= EAU_IDLE;
		@(posedge sys_clk_in);
		mode_in <= EAU_PRE_DEC;
		rst_n_in <= 1'b0;
		#1 check({addr_valid_out, operand_valid_out, wb_en_out}, 32'h0);
		@(posedge sys_clk_in);
		#1 check({wb_en_out, valid_out} | addr_out, 32'h0);
		rst_n_in <= 1'b1;
		// First request after a mid-run reset must be taken normally
		@(posedge sys_clk_in);
		valid_in <= 1'b0;
		#1 check(addr_out, 32'hFF);
		check({28'h0, wb_sel}, 32'h5);
		$display("reset and idle done");
		results();
	end
endmodule
`default_nettype wire
